// ---- inc/p2s_pkg.sv ----
// Constants for the port 2 flow control and energy-saving strap loader.
package p2s_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] FLOW_OFS    = 8'h00;
    localparam logic [7:0] ADVERT_OFS  = 8'h04;
    localparam logic [7:0] MACTX_OFS   = 8'h08;
    localparam logic [7:0] PHYCFG_OFS  = 8'h0C;
    localparam logic [7:0] EEECAP_OFS  = 8'h10;
    localparam logic [7:0] EEEADV_OFS  = 8'h14;
    localparam logic [7:0] STATUS_OFS  = 8'h18;

    // Field positions in the flow control register.
    localparam int FLOW_BP_BIT     = 0;
    localparam int FLOW_TX_BIT     = 1;
    localparam int FLOW_RX_BIT     = 2;
    localparam int FLOW_MANUAL_BIT = 3;

    // Field positions in the PHY advertisement register.
    localparam int ADV_SYM_BIT  = 10;
    localparam int ADV_ASYM_BIT = 11;

    // Energy-saving enable positions.
    localparam int MACTX_EEE_BIT  = 0;
    localparam int PHYCFG_EEE_BIT = 0;
    localparam int EEE_100TX_BIT  = 1;

    // Status register fields.
    localparam int STAT_DONE_BIT  = 0;
    localparam int STAT_FX_BIT    = 1;
    localparam int STAT_STRAP_LSB = 2;

    // Strap vector layout and default values of the straps.
    localparam int STRAP_W     = 4;
    localparam int STRAP_BP    = 0;
    localparam int STRAP_FDFC  = 1;
    localparam int STRAP_MAN   = 2;
    localparam int STRAP_EEE   = 3;
    localparam logic BP_DEFAULT   = 1'b1;
    localparam logic FDFC_DEFAULT = 1'b1;
    localparam logic MAN_DEFAULT  = 1'b0;
    localparam logic EEE_DEFAULT  = 1'b0;

    // Cycles waited after reset so the strap synchronisers hold pin values.
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    // Loader states.
    typedef enum logic [1:0] {
        P2S_SETTLE = 2'b01,
        P2S_RUN    = 2'b10
    } p2s_state_t;

endpackage

// ---- src/p2s_strap_loader.sv ----
// Port 2 flow control and energy-saving strap defaults with APB registers.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

// What this block does
// RL1 - Backpressure strap is reset default of port 2 backpressure enable.
// RL2 - Full-duplex flow strap sets both transmit and receive pause enables.
// RL3 - Full-duplex flow strap also sets PHY asymmetric pause advertisement.
// RL4 - Manual flow strap becomes reset default of manual flow select.
// RL5 - Manual flow strap also affects PHY symmetric and asymmetric pause.
// RL6 - In fibre mode straps do not touch PHY pause or energy bits.
// RL7 - Energy-saving strap sets MAC transmit energy-saving enable default.
// RL8 - Energy-saving strap sets PHY enable, capability and advert bits.
// RL9 - In fibre mode energy-saving operation on port 2 ends disabled.
// RL10 - Straps only give reset defaults; later software writes override them.
module p2s_strap_loader (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // Strap pins, asynchronous to clk.
    input  wire logic        port2_backpressure_strap,
    input  wire logic        port2_fullduplex_flow_strap,
    input  wire logic        port2_manual_flow_strap,
    input  wire logic        energy_saving_strap_pin,
    input  wire logic        phy_fibre_mode,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Configuration bits to the port 2 MAC and PHY.
    output logic             port2_backpressure_enable,
    output logic             port2_tx_pause_enable,
    output logic             port2_rx_pause_enable,
    output logic             port2_manual_flow_select,
    output logic             phy_advert_sym_pause,
    output logic             phy_advert_asym_pause,
    output logic             mac_energy_saving_enable,
    output logic             phy_energy_saving_enable,
    output logic             phy_eee_cap_100tx,
    output logic             phy_eee_adv_100tx,
    output logic             port2_energy_saving_active,
    output logic             strap_load_done
);

    ////////////////////////////////////////////////////////////////////////
    // Strap synchronisers.

    logic [p2s_pkg::STRAP_W:0] strap_meta_r;
    logic [p2s_pkg::STRAP_W:0] strap_sync_r;
    logic [p2s_pkg::STRAP_W-1:0] strap_latch_r;
    logic                        fx_r;

    // Pins pass two flops before any logic looks at them.
    always_ff @(posedge clk) begin
        strap_meta_r <= {phy_fibre_mode, energy_saving_strap_pin,
                         port2_manual_flow_strap,
                         port2_fullduplex_flow_strap,
                         port2_backpressure_strap};
        strap_sync_r <= strap_meta_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Load sequencer.

    p2s_pkg::p2s_state_t state_r;
    logic [1:0]          settle_cnt_r;
    logic                load_now;

    assign load_now = (state_r == p2s_pkg::P2S_SETTLE) &&
                      (settle_cnt_r == p2s_pkg::SETTLE_CYCLES);

    // Waits until the synchronisers are filled, then loads once.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r      <= p2s_pkg::P2S_SETTLE;
            settle_cnt_r <= 2'h0;
        end else begin
            case (state_r)
                p2s_pkg::P2S_SETTLE: begin
                    settle_cnt_r <= settle_cnt_r + 2'h1;
                    if (load_now) begin
                        state_r <= p2s_pkg::P2S_RUN;
                    end
                end
                p2s_pkg::P2S_RUN: begin
                    state_r <= p2s_pkg::P2S_RUN;
                end
                default: begin
                    state_r <= p2s_pkg::P2S_SETTLE;
                end
            endcase
        end
    end

    // Captured strap values, visible in the status register.
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_latch_r <= {p2s_pkg::EEE_DEFAULT, p2s_pkg::MAN_DEFAULT,
                              p2s_pkg::FDFC_DEFAULT, p2s_pkg::BP_DEFAULT};
            fx_r          <= 1'b0;
        end else if (load_now) begin
            strap_latch_r <= strap_sync_r[p2s_pkg::STRAP_W-1:0];
            fx_r          <= strap_sync_r[p2s_pkg::STRAP_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic wr_en;
    logic sw_access;

    // Software is held off until the straps have been applied.
    assign sw_access = psel && penable && !pready && (state_r ==
                       p2s_pkg::P2S_RUN); // RL10
    assign wr_en     = psel && penable && pready && pwrite;

    // Derived defaults from the synchronised straps.
    logic s_bp;
    logic s_fdfc;
    logic s_man;
    logic s_eee;
    logic s_fx;
    assign s_bp   = strap_sync_r[p2s_pkg::STRAP_BP];
    assign s_fdfc = strap_sync_r[p2s_pkg::STRAP_FDFC];
    assign s_man  = strap_sync_r[p2s_pkg::STRAP_MAN];
    assign s_eee  = strap_sync_r[p2s_pkg::STRAP_EEE];
    assign s_fx   = strap_sync_r[p2s_pkg::STRAP_W];

    ////////////////////////////////////////////////////////////////////////
    // Switch port 2 flow control bits.

    // Strap load wins only at the load point; writes rule afterwards.
    always_ff @(posedge clk) begin
        if (reset) begin
            port2_backpressure_enable <= p2s_pkg::BP_DEFAULT;
            port2_tx_pause_enable     <= p2s_pkg::FDFC_DEFAULT;
            port2_rx_pause_enable     <= p2s_pkg::FDFC_DEFAULT;
            port2_manual_flow_select  <= p2s_pkg::MAN_DEFAULT;
        end else if (load_now) begin
            port2_backpressure_enable <= s_bp;   // RL1
            port2_tx_pause_enable     <= s_fdfc; // RL2
            port2_rx_pause_enable     <= s_fdfc; // RL2
            port2_manual_flow_select  <= s_man;  // RL4
        end else if (wr_en && paddr == p2s_pkg::FLOW_OFS) begin
            port2_backpressure_enable <= pwdata[p2s_pkg::FLOW_BP_BIT]; // RL10
            port2_tx_pause_enable     <= pwdata[p2s_pkg::FLOW_TX_BIT];
            port2_rx_pause_enable     <= pwdata[p2s_pkg::FLOW_RX_BIT];
            port2_manual_flow_select  <= pwdata[p2s_pkg::FLOW_MANUAL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PHY pause advertisement.

    // Manual flow control suppresses pause advertisement; fibre clears it.
    always_ff @(posedge clk) begin
        if (reset) begin
            phy_advert_sym_pause  <= 1'b0;
            phy_advert_asym_pause <= 1'b0;
        end else if (load_now) begin
            phy_advert_sym_pause  <= !s_fx && !s_man && s_fdfc; // RL5 RL6
            phy_advert_asym_pause <= !s_fx && !s_man && s_fdfc; // RL3 RL5
        end else if (wr_en && paddr == p2s_pkg::ADVERT_OFS) begin
            phy_advert_sym_pause  <= pwdata[p2s_pkg::ADV_SYM_BIT];
            phy_advert_asym_pause <= pwdata[p2s_pkg::ADV_ASYM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Energy-saving enables in MAC and PHY.

    // In fibre mode no energy-saving result exists, so all start off.
    always_ff @(posedge clk) begin
        if (reset) begin
            mac_energy_saving_enable <= p2s_pkg::EEE_DEFAULT;
            phy_energy_saving_enable <= p2s_pkg::EEE_DEFAULT;
            phy_eee_cap_100tx        <= p2s_pkg::EEE_DEFAULT;
            phy_eee_adv_100tx        <= p2s_pkg::EEE_DEFAULT;
        end else if (load_now) begin
            mac_energy_saving_enable <= s_eee && !s_fx; // RL7 RL9
            phy_energy_saving_enable <= s_eee && !s_fx; // RL8 RL6
            phy_eee_cap_100tx        <= s_eee && !s_fx; // RL8 RL6
            phy_eee_adv_100tx        <= s_eee && !s_fx; // RL8 RL6
        end else if (wr_en) begin
            if (paddr == p2s_pkg::MACTX_OFS) begin
                mac_energy_saving_enable <= pwdata[p2s_pkg::MACTX_EEE_BIT];
            end
            if (paddr == p2s_pkg::PHYCFG_OFS) begin
                phy_energy_saving_enable <= pwdata[p2s_pkg::PHYCFG_EEE_BIT];
            end
            if (paddr == p2s_pkg::EEECAP_OFS) begin
                phy_eee_cap_100tx <= pwdata[p2s_pkg::EEE_100TX_BIT];
            end
            if (paddr == p2s_pkg::EEEADV_OFS) begin
                phy_eee_adv_100tx <= pwdata[p2s_pkg::EEE_100TX_BIT];
            end
        end
    end

    // Even if software sets the enable, fibre mode keeps the port idle-free.
    always_ff @(posedge clk) begin
        if (reset) begin
            port2_energy_saving_active <= 1'b0;
            strap_load_done            <= 1'b0;
        end else begin
            port2_energy_saving_active <= mac_energy_saving_enable &&
                                          !fx_r; // RL9
            strap_load_done            <= (state_r == p2s_pkg::P2S_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, read data and error set with pready.

    logic [31:0] rd_nxt;
    logic        err_nxt;

    always_comb begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            p2s_pkg::FLOW_OFS: begin
                rd_nxt[p2s_pkg::FLOW_BP_BIT]     = port2_backpressure_enable;
                rd_nxt[p2s_pkg::FLOW_TX_BIT]     = port2_tx_pause_enable;
                rd_nxt[p2s_pkg::FLOW_RX_BIT]     = port2_rx_pause_enable;
                rd_nxt[p2s_pkg::FLOW_MANUAL_BIT] = port2_manual_flow_select;
            end
            p2s_pkg::ADVERT_OFS: begin
                rd_nxt[p2s_pkg::ADV_SYM_BIT]  = phy_advert_sym_pause;
                rd_nxt[p2s_pkg::ADV_ASYM_BIT] = phy_advert_asym_pause;
            end
            p2s_pkg::MACTX_OFS: begin
                rd_nxt[p2s_pkg::MACTX_EEE_BIT] = mac_energy_saving_enable;
            end
            p2s_pkg::PHYCFG_OFS: begin
                rd_nxt[p2s_pkg::PHYCFG_EEE_BIT] = phy_energy_saving_enable;
            end
            p2s_pkg::EEECAP_OFS: begin
                rd_nxt[p2s_pkg::EEE_100TX_BIT] = phy_eee_cap_100tx;
            end
            p2s_pkg::EEEADV_OFS: begin
                rd_nxt[p2s_pkg::EEE_100TX_BIT] = phy_eee_adv_100tx;
            end
            p2s_pkg::STATUS_OFS: begin
                rd_nxt[p2s_pkg::STAT_DONE_BIT] = strap_load_done;
                rd_nxt[p2s_pkg::STAT_FX_BIT]   = fx_r;
                rd_nxt[p2s_pkg::STAT_STRAP_LSB +: p2s_pkg::STRAP_W] =
                    strap_latch_r;
                err_nxt = pwrite; // Status is read only.
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // Registered answer so every bus output comes from a flop.
    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= sw_access;
            pslverr <= sw_access && err_nxt;
            prdata  <= (sw_access && !pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

endmodule

// ---- tb/p2s_strap_src.sv ----
// Board-side model that holds the strap pins and fibre-mode pin levels.
`timescale 1ns/1ps
module p2s_strap_src (
    // Strap settings chosen by the bench.
    input  wire logic [4:0] cfg,
    // Pins {fibre, energy, manual, full-duplex, backpressure}.
    output logic      [4:0] pins
);
    // Straps are static board levels, so they simply follow the setting.
    assign pins = cfg;
endmodule

// ---- tb/p2s_strap_monitor.sv ----
// Checker for the strap loader's APB and configuration ports.
`timescale 1ns/1ps
module p2s_strap_monitor (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        reset,
    // Strap pins.
    input wire logic        port2_backpressure_strap,
    input wire logic        port2_fullduplex_flow_strap,
    input wire logic        port2_manual_flow_strap,
    input wire logic        energy_saving_strap_pin,
    input wire logic        phy_fibre_mode,
    // APB slave.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Configuration outputs.
    input wire logic        port2_backpressure_enable,
    input wire logic        port2_tx_pause_enable,
    input wire logic        port2_rx_pause_enable,
    input wire logic        port2_manual_flow_select,
    input wire logic        phy_advert_sym_pause,
    input wire logic        phy_advert_asym_pause,
    input wire logic        mac_energy_saving_enable,
    input wire logic        phy_energy_saving_enable,
    input wire logic        phy_eee_cap_100tx,
    input wire logic        phy_eee_adv_100tx,
    input wire logic        port2_energy_saving_active,
    input wire logic        strap_load_done
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // Bus answers: one-cycle pulse, one wait state once loaded.
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_timing_a: assert property (psel && penable && !pready &&
        strap_load_done |=> pready) else $error("pready late");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero when idle");
    ////////////////////////////////////////////////////////////////////////
    // Defaults right after reset, then strap values once loaded.
    reset_value_a: assert property ($fell(reset) |->
        port2_tx_pause_enable && port2_rx_pause_enable
        && port2_backpressure_enable && !port2_manual_flow_select)
        else $error("wrong reset default");
    flow_load_a: assert property ($rose(strap_load_done) |->
        port2_backpressure_enable == port2_backpressure_strap
        && port2_tx_pause_enable == port2_fullduplex_flow_strap
        && port2_rx_pause_enable == port2_fullduplex_flow_strap
        && port2_manual_flow_select == port2_manual_flow_strap)
        else $error("flow bits not loaded");
    advert_load_a: assert property ($rose(strap_load_done) |->
        {phy_advert_sym_pause, phy_advert_asym_pause} == {2{
        port2_fullduplex_flow_strap & !port2_manual_flow_strap
        & !phy_fibre_mode}}) else $error("pause advert wrong");
    energy_load_a: assert property ($rose(strap_load_done) |->
        {mac_energy_saving_enable, phy_energy_saving_enable,
        phy_eee_cap_100tx, phy_eee_adv_100tx} == {4{energy_saving_strap_pin
        & !phy_fibre_mode}}) else $error("energy bits wrong");
    fibre_off_a: assert property (strap_load_done && phy_fibre_mode |->
        !port2_energy_saving_active) else $error("energy on in fibre");
    config_hold_a: assert property ($past(strap_load_done) &&
        !$past(pready && pwrite) |-> $stable({port2_backpressure_enable,
        port2_tx_pause_enable, port2_rx_pause_enable,
        port2_manual_flow_select, phy_advert_sym_pause,
        phy_advert_asym_pause, mac_energy_saving_enable,
        phy_energy_saving_enable, phy_eee_cap_100tx, phy_eee_adv_100tx}))
        else $error("config changed without write");
    // Main scenarios reached.
    cover property ($rose(strap_load_done) && phy_fibre_mode);
    cover property (pready && pslverr);
    cover property (pready && pwrite && !pslverr);
endmodule

bind p2s_strap_loader p2s_strap_monitor mon_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .port2_backpressure_strap(port2_backpressure_strap),
    .port2_fullduplex_flow_strap(port2_fullduplex_flow_strap),
    .port2_manual_flow_strap(port2_manual_flow_strap),
    .energy_saving_strap_pin(energy_saving_strap_pin),
    .phy_fibre_mode(phy_fibre_mode), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port2_backpressure_enable(port2_backpressure_enable),
    .port2_tx_pause_enable(port2_tx_pause_enable),
    .port2_rx_pause_enable(port2_rx_pause_enable),
    .port2_manual_flow_select(port2_manual_flow_select),
    .phy_advert_sym_pause(phy_advert_sym_pause),
    .phy_advert_asym_pause(phy_advert_asym_pause),
    .mac_energy_saving_enable(mac_energy_saving_enable),
    .phy_energy_saving_enable(phy_energy_saving_enable),
    .phy_eee_cap_100tx(phy_eee_cap_100tx),
    .phy_eee_adv_100tx(phy_eee_adv_100tx),
    .port2_energy_saving_active(port2_energy_saving_active),
    .strap_load_done(strap_load_done)
);

// ---- tb/p2s_strap_loader_tb.sv ----
// Self-checking bench for the port 2 strap loader.
`timescale 1ns/1ps
module p2s_strap_loader_tb;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, e;
    wire         pready, pslverr, act, done;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, q;
    wire  [31:0] prdata;
    logic [4:0]  cfg = 5'h03;
    wire  [4:0]  pins;
    wire  [9:0]  outs;
    int          num_errors = 0, tests_run = 0;

    p2s_strap_src src_u (.cfg(cfg), .pins(pins));
    p2s_strap_loader dut_u (.clk(clk), .reset(reset),
        .port2_backpressure_strap(pins[0]),
        .port2_fullduplex_flow_strap(pins[1]),
        .port2_manual_flow_strap(pins[2]), .energy_saving_strap_pin(pins[3]),
        .phy_fibre_mode(pins[4]), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .port2_backpressure_enable(outs[0]), .port2_tx_pause_enable(outs[1]),
        .port2_rx_pause_enable(outs[2]), .port2_manual_flow_select(outs[3]),
        .phy_advert_sym_pause(outs[4]), .phy_advert_asym_pause(outs[5]),
        .mac_energy_saving_enable(outs[6]), .phy_energy_saving_enable(outs[7]),
        .phy_eee_cap_100tx(outs[8]), .phy_eee_adv_100tx(outs[9]),
        .port2_energy_saving_active(act), .strap_load_done(done));

    // Free-running 100 MHz clock.
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Compare, count and report.
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic ee);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 60);
        // A slave that never answers is a failure, not a silent skip.
        if (pready !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t: no pready", $time);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, e}, {31'h0, ee});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, 1'b0);
        chk(q, x);
    endtask

    // Reset with given straps; the first read is issued before load ends.
    task automatic boot(input logic [4:0] c);
        logic a, x;
        reset <= 1'b1;
        cfg   <= c;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        a = c[1] & ~c[2] & ~c[4];
        x = c[3] & ~c[4];
        rd(p2s_pkg::FLOW_OFS, {28'h0, c[2], c[1], c[1], c[0]});
        rd(p2s_pkg::ADVERT_OFS, {20'h0, a, a, 10'h0});
        rd(p2s_pkg::MACTX_OFS, {31'h0, x});
        rd(p2s_pkg::PHYCFG_OFS, {31'h0, x});
        rd(p2s_pkg::EEECAP_OFS, {30'h0, x, 1'b0});
        rd(p2s_pkg::EEEADV_OFS, {30'h0, x, 1'b0});
        rd(p2s_pkg::STATUS_OFS, {26'h0, c[3:0], c[4], 1'b1});
        chk({22'h0, outs}, {22'h0, {4{x}}, a, a, c[2], c[1], c[1], c[0]});
        chk({31'h0, act}, {31'h0, x});
    endtask

    task automatic results;
        $display("tests_run %0d num_errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Every strap and fibre combination, then overrides and refusals.
    initial begin
        for (int i = 0; i < 32; i++) begin
            boot(5'(i));
            $display("strap set %b done", 5'(i));
        end
        boot(5'h0F);
        apb(1'b1, p2s_pkg::FLOW_OFS, 32'h0000_0006, 1'b0);
        apb(1'b1, p2s_pkg::ADVERT_OFS, 32'h0000_0400, 1'b0);
        apb(1'b1, p2s_pkg::MACTX_OFS, 32'h0000_0000, 1'b0);
        rd(p2s_pkg::FLOW_OFS, 32'h0000_0006);
        chk({22'h0, outs}, 32'h0000_0396);
        chk({31'h0, act}, 32'h0000_0000);
        apb(1'b1, p2s_pkg::STATUS_OFS, 32'h0000_0000, 1'b1);
        rd(p2s_pkg::STATUS_OFS, 32'h0000_003D);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 8'h1C, 32'h0000_0000, 1'b1);
        chk(q, 32'h0000_0000);
        chk({22'h0, outs}, 32'h0000_0396);
        $display("override and refusal done");
        // Fibre mode: software may set energy bits, port stays inactive.
        boot(5'h1F);
        apb(1'b1, p2s_pkg::MACTX_OFS, 32'h0000_0001, 1'b0);
        apb(1'b1, p2s_pkg::PHYCFG_OFS, 32'h0000_0001, 1'b0);
        apb(1'b1, p2s_pkg::EEECAP_OFS, 32'h0000_0002, 1'b0);
        apb(1'b1, p2s_pkg::EEEADV_OFS, 32'h0000_0002, 1'b0);
        rd(p2s_pkg::MACTX_OFS, 32'h0000_0001);
        chk({22'h0, outs}, 32'h0000_03CF);
        chk({31'h0, act}, 32'h0000_0000);
        $display("fibre override done");
        boot(5'h0F);
        $display("defaults restored");
        results();
    end

    // Watchdog well beyond the expected run of about 1250 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule
